// ===== gler_pkg.sv
// Purpose: shared constants and carriers for the low pin event router
// Assumes: one 32-bit route register at a fixed register-port offset
// Notes: four bits per pin, pin n owns bits 4n+3 down to 4n
package gler_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int GLER_ADDR_W = 8;
	localparam int GLER_DATA_W = 32;
	localparam logic [GLER_ADDR_W-1:0] GLER_ROUTE_OFS = 8'he0;
	localparam logic [GLER_DATA_W-1:0] GLER_ROUTE_RST = 32'h0000_0000;
	localparam logic [GLER_DATA_W-1:0] GLER_READ_ZERO = 32'h0000_0000;

	// ----------------------------------------
	// per-pin field layout
	// ----------------------------------------
	localparam int GLER_PINS = 8;
	localparam int GLER_FIELD_W = 8;
	localparam int GLER_SLOT_W = 4;
	localparam int GLER_POS_W = 3;
	localparam int GLER_GRP_BIT = 3;
	localparam logic GLER_GRP_INT = 1'b0;
	localparam logic GLER_GRP_PME = 1'b1;
	localparam logic [GLER_FIELD_W-1:0] GLER_ONE_HOT0 = 8'h01;
	localparam logic [GLER_FIELD_W-1:0] GLER_FIELD_ZERO = 8'h00;

	// register-port request
	typedef struct packed {
		logic [GLER_ADDR_W-1:0] addr;
		logic wr;
		logic rd;
		logic [GLER_DATA_W-1:0] wdata;
	} gler_reg_req_t;

	// the two output fields towards the mapper
	typedef struct packed {
		logic [GLER_FIELD_W-1:0] power_wake_event_field;
		logic [GLER_FIELD_W-1:0] int_field;
	} gler_fields_t;

endpackage

// ===== gler_pin_route.sv
// Purpose: steer one pin's event to one bit of one output field
// Assumes: event and selects are on the register clock
// Notes: purely combinational; the top registers the merged result
`timescale 1ns/1ps
`default_nettype none
module gler_pin_route
	import gler_pkg::*;
(
	input wire logic pin_event,
	input wire logic group_select,
	input wire logic [gler_pkg::GLER_POS_W-1:0] bit_select,
	output logic [gler_pkg::GLER_FIELD_W-1:0] int_vec,
	output logic [gler_pkg::GLER_FIELD_W-1:0] pme_vec
);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire [GLER_FIELD_W-1:0] hot = pin_event ? (GLER_ONE_HOT0 << bit_select) : GLER_FIELD_ZERO; // R2
	wire to_pme = (group_select == GLER_GRP_PME); // R1

	// only one of the two fields ever sees this pin
	assign int_vec = to_pme ? GLER_FIELD_ZERO : hot; // R1
	assign pme_vec = to_pme ? hot : GLER_FIELD_ZERO; // R1

endmodule // gler_pin_route
`default_nettype wire

// ===== gler_top.sv
// Purpose: route events of pins 0..7 into the interrupt or wake field
// Assumes: register port and event inputs share the one clock
// Notes: outputs lag events by one clock; reads answer one clock later
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: group bit 0 interrupt field, 1 wake field
// R2: three-bit value n selects field bit n
// R3: pin 7 fields at bit 31, 30:28
// R4: pin 6 fields at bit 27, 26:24
// R5: pin 5 fields at bit 23, 22:20
// R6: pin 4 fields at bit 19, 18:16
// R7: pin 3 fields at bit 15, 14:12
// R8: pin 2 fields at bit 11, 10:8
// R9: pin 1 fields at bit 7, 6:4
// R10: pin 0 fields at bit 3, 2:0
// R11: shared destination bits OR the events together
// R12: reset clears all selects to zero
module gler_top
	import gler_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire gler_pkg::gler_reg_req_t reg_req,
	output logic [gler_pkg::GLER_DATA_W-1:0] reg_rdata,
	input wire logic [gler_pkg::GLER_PINS-1:0] pin_event,
	output gler_pkg::gler_fields_t fields
);
	import gler_pkg::*;

	logic [GLER_DATA_W-1:0] route_reg;
	logic [GLER_DATA_W-1:0] route_next;
	logic [GLER_DATA_W-1:0] rdata_reg;
	logic [GLER_DATA_W-1:0] rdata_next;
	gler_fields_t fields_reg;
	gler_fields_t fields_next;
	logic [GLER_FIELD_W-1:0] int_part [GLER_PINS];
	logic [GLER_FIELD_W-1:0] pme_part [GLER_PINS];

	// ----------------------------------------
	// register port decode
	// ----------------------------------------
	// only the exact offset is mapped; other writes are dropped silently
	wire hit = (reg_req.addr == GLER_ROUTE_OFS);
	wire wr_hit = reg_req.wr && hit;
	wire rd_hit = reg_req.rd && hit;

	assign route_next = wr_hit ? reg_req.wdata : route_reg;
	// unmapped reads answer zero so software sees a defined value
	assign rdata_next = rd_hit ? route_reg : (reg_req.rd ? GLER_READ_ZERO : rdata_reg);

	// route register and read data
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			route_reg <= GLER_ROUTE_RST; // R12
			rdata_reg <= GLER_READ_ZERO;
		end else begin
			route_reg <= route_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// ----------------------------------------
	// per-pin steering
	// ----------------------------------------
	// pin n owns the nibble at 4n: group bit on top, position below
	for (genvar p = 0; p < GLER_PINS; p++) begin : g_pin
		gler_pin_route u_route (
			.pin_event(pin_event[p]),
			.group_select(route_reg[p*GLER_SLOT_W+GLER_GRP_BIT]), // R3 R4 R5 R6 R7 R8 R9 R10
			.bit_select(route_reg[p*GLER_SLOT_W +: GLER_POS_W]), // R3 R4 R5 R6 R7 R8 R9 R10
			.int_vec(int_part[p]),
			.pme_vec(pme_part[p])
		);
	end

	// merge all pins; a plain OR keeps pins on a shared bit from masking each other
	always_comb begin
		fields_next.int_field = GLER_FIELD_ZERO;
		fields_next.power_wake_event_field = GLER_FIELD_ZERO;
		for (int p = 0; p < GLER_PINS; p++) begin
			fields_next.int_field = fields_next.int_field | int_part[p]; // R11
			fields_next.power_wake_event_field = fields_next.power_wake_event_field | pme_part[p]; // R11
		end
	end

	// registered fields, so the mapper sees glitch-free levels
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fields_reg <= '0;
		end else begin
			fields_reg <= fields_next;
		end
	end

	assign fields = fields_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic seen_clock_reg;

	// marks the first clock after reset release
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			seen_clock_reg <= 1'b0;
		end else begin
			seen_clock_reg <= 1'b1;
		end
	end

	property p_pin0_int;
		@(posedge clock) disable iff (!arst_n)
		(pin_event == 8'h01 && route_reg[3] == GLER_GRP_INT)
		|=> (fields.int_field == (GLER_ONE_HOT0 << $past(route_reg[2:0])))
		&& (fields.power_wake_event_field == GLER_FIELD_ZERO);
	endproperty
	a_pin0_int: assert property (p_pin0_int) else $error("pin 0 missed its interrupt bit"); // R10

	property p_pin7_pme;
		@(posedge clock) disable iff (!arst_n)
		(pin_event == 8'h80 && route_reg[31] == GLER_GRP_PME)
		|=> (fields.power_wake_event_field == (GLER_ONE_HOT0 << $past(route_reg[30:28])))
		&& (fields.int_field == GLER_FIELD_ZERO);
	endproperty
	a_pin7_pme: assert property (p_pin7_pme) else $error("pin 7 missed its wake bit"); // R3

	property p_pin6_pos;
		@(posedge clock) disable iff (!arst_n)
		(pin_event == 8'h40 && route_reg[27] == GLER_GRP_INT)
		|=> fields.int_field == (GLER_ONE_HOT0 << $past(route_reg[26:24]));
	endproperty
	a_pin6_pos: assert property (p_pin6_pos) else $error("pin 6 landed on wrong bit"); // R4

	property p_pin5_pme;
		@(posedge clock) disable iff (!arst_n)
		(pin_event == 8'h20 && route_reg[23] == GLER_GRP_PME)
		|=> (fields.power_wake_event_field == (GLER_ONE_HOT0 << $past(route_reg[22:20])))
		&& (fields.int_field == GLER_FIELD_ZERO);
	endproperty
	a_pin5_pme: assert property (p_pin5_pme) else $error("pin 5 missed its wake bit"); // R5

	property p_pin4_int;
		@(posedge clock) disable iff (!arst_n)
		(pin_event == 8'h10 && route_reg[19] == GLER_GRP_INT)
		|=> (fields.int_field == (GLER_ONE_HOT0 << $past(route_reg[18:16])))
		&& (fields.power_wake_event_field == GLER_FIELD_ZERO);
	endproperty
	a_pin4_int: assert property (p_pin4_int) else $error("pin 4 missed its int bit"); // R6

	property p_pin3_pos;
		@(posedge clock) disable iff (!arst_n)
		(pin_event == 8'h08 && route_reg[15] == GLER_GRP_PME)
		|=> fields.power_wake_event_field == (GLER_ONE_HOT0 << $past(route_reg[14:12]));
	endproperty
	a_pin3_pos: assert property (p_pin3_pos) else $error("pin 3 landed on wrong bit"); // R7

	property p_pin2_pos;
		@(posedge clock) disable iff (!arst_n)
		(pin_event == 8'h04 && route_reg[11] == GLER_GRP_INT)
		|=> fields.int_field == (GLER_ONE_HOT0 << $past(route_reg[10:8]));
	endproperty
	a_pin2_pos: assert property (p_pin2_pos) else $error("pin 2 landed on wrong bit"); // R8

	property p_pin1_pos;
		@(posedge clock) disable iff (!arst_n)
		(pin_event == 8'h02 && route_reg[7] == GLER_GRP_PME)
		|=> fields.power_wake_event_field == (GLER_ONE_HOT0 << $past(route_reg[6:4]));
	endproperty
	a_pin1_pos: assert property (p_pin1_pos) else $error("pin 1 landed on wrong bit"); // R9

	property p_group_split;
		@(posedge clock) disable iff (!arst_n)
		(pin_event == 8'h08 && route_reg[15] == GLER_GRP_PME)
		|=> fields.int_field == GLER_FIELD_ZERO;
	endproperty
	a_group_split: assert property (p_group_split) else $error("wake pin leaked to interrupt"); // R1

	property p_quiet;
		@(posedge clock) disable iff (!arst_n)
		(pin_event == 8'h00) |=> (fields == '0);
	endproperty
	a_quiet: assert property (p_quiet) else $error("field bit set without an event"); // R11

	property p_shared_or;
		@(posedge clock) disable iff (!arst_n)
		(pin_event[0] && pin_event[1] && route_reg[7:4] == route_reg[3:0]
			&& route_reg[3] == GLER_GRP_INT)
		|=> fields.int_field[$past(route_reg[2:0])];
	endproperty
	a_shared_or: assert property (p_shared_or) else $error("shared bit lost an event"); // R11

	property p_reset_clear;
		@(posedge clock) disable iff (!arst_n)
		!seen_clock_reg |-> (route_reg == GLER_ROUTE_RST);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("route not cleared by reset"); // R12

	property p_write_read;
		@(posedge clock) disable iff (!arst_n)
		(wr_hit && !reg_req.rd) ##1 (rd_hit && !reg_req.wr)
		|=> reg_rdata == $past(reg_req.wdata, 2);
	endproperty
	a_write_read: assert property (p_write_read) else $error("readback differs from write"); // R3

	property p_pin0_pos;
		@(posedge clock) disable iff (!arst_n)
		(pin_event == 8'h01 && route_reg[3:0] == 4'h7) |=> fields.int_field == 8'h80;
	endproperty
	a_pin0_pos: assert property (p_pin0_pos) else $error("position seven not decoded"); // R2

	property p_unmapped;
		@(posedge clock) disable iff (!arst_n)
		(reg_req.rd && !hit) |=> reg_rdata == GLER_READ_ZERO;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	c_int_route: cover property (@(posedge clock) disable iff (!arst_n)
		fields.int_field != GLER_FIELD_ZERO);
	c_pme_route: cover property (@(posedge clock) disable iff (!arst_n)
		fields.power_wake_event_field != GLER_FIELD_ZERO);
	c_write_then_event: cover property (@(posedge clock) disable iff (!arst_n)
		wr_hit ##1 (pin_event != 8'h00) ##1 (fields != '0));
	// back-to-back write then read of the route word
	c_back_to_back: cover property (@(posedge clock) disable iff (!arst_n)
		wr_hit ##1 rd_hit);

endmodule // gler_top
`default_nettype wire

// ===== gler_mapper_model.sv
// Purpose: stand-in for the interrupt and wake mapper downstream
// Assumes: field bits are active-high levels on the register clock
// Notes: only flags whether each field has any bit set
`timescale 1ns/1ps
`default_nettype none
module gler_mapper_model
	import gler_pkg::*;
(
	input wire gler_pkg::gler_fields_t fields,
	output logic int_req,
	output logic wake_req
);
	// any set bit raises a request; priority is not modelled
	assign int_req = |fields.int_field;
	assign wake_req = |fields.power_wake_event_field;
endmodule // gler_mapper_model
`default_nettype wire

// ===== tb_gpio_low_event_router.sv
// Purpose: self-checking bench for the low pin event router
// Assumes: fields lag events one clock, reads answer a clock later
// Notes: expected fields are rebuilt from the nibble layout here
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_low_event_router;
	import gler_pkg::*;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	gler_reg_req_t reg_req = '0;
	logic [GLER_DATA_W-1:0] reg_rdata;
	logic [GLER_PINS-1:0] pin_event = 8'h00;
	gler_fields_t fields;
	logic int_req;
	logic wake_req;
	int fail_count = 0;
	int n_tests = 0;
	logic [31:0] route_exp = 32'h0;
	always #50 clock = ~clock;
	gler_top dut (.clock(clock), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.pin_event(pin_event), .fields(fields));
	gler_mapper_model mapper (.fields(fields), .int_req(int_req), .wake_req(wake_req));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clock);
		reg_req.wr <= 1'b0;
	endtask
	// one spare edge so the answer has surely landed
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 32'h0};
		@(posedge clock);
		reg_req.rd <= 1'b0;
		@(posedge clock);
		#1 d = reg_rdata;
	endtask
	// write taken at one edge, read taken at the very next one
	task automatic reg_wr_rd(input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
		@(posedge clock);
		reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: wd};
		@(posedge clock);
		reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: wd};
		@(posedge clock);
		reg_req.rd <= 1'b0;
		@(posedge clock);
		#1 d = reg_rdata;
	endtask
	function automatic gler_fields_t exp_fields(input logic [31:0] r, input logic [7:0] ev);
		gler_fields_t f;
		f = '0;
		for (int p = 0; p < 8; p++) begin
			if (ev[p] && r[4*p+3]) f.power_wake_event_field[r[4*p+:3]] = 1'b1;
			else if (ev[p]) f.int_field[r[4*p+:3]] = 1'b1;
		end
		return f;
	endfunction
	task automatic fire(input logic [7:0] ev);
		@(posedge clock);
		pin_event <= ev;
		@(posedge clock);
		#1 chk(32'(fields), 32'(exp_fields(route_exp, ev)));
	endtask
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		#3_000_000;
		fail_count++;
		complete_run();
	end
	initial begin
		logic [31:0] d;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		reg_read(GLER_ROUTE_OFS, d);
		chk(d, GLER_ROUTE_RST);
		fire(8'hff);
		chk({30'h0, wake_req, int_req}, 32'h1);
		$display("reset test done");
		// every pin, every bit position, both groups
		for (int p = 0; p < 8; p++) begin
			for (int n = 0; n < 16; n++) begin
				route_exp = 32'(n[3:0]) << (4*p);
				reg_write(GLER_ROUTE_OFS, route_exp);
				reg_read(GLER_ROUTE_OFS, d);
				chk(d, route_exp);
				fire(8'h01 << p);
			end
		end
		$display("route sweep test done");
		// shared destinations merge by OR
		route_exp = 32'hffff_ffff;
		reg_write(GLER_ROUTE_OFS, route_exp);
		fire(8'hff);
		chk({30'h0, wake_req, int_req}, 32'h2);
		route_exp = 32'h0000_7777;
		reg_write(GLER_ROUTE_OFS, route_exp);
		fire(8'hff);
		fire(8'h00);
		$display("merge test done");
		// other addresses neither write nor read the route
		reg_write(8'he4, 32'h1234_5678);
		reg_read(GLER_ROUTE_OFS, d);
		chk(d, route_exp);
		reg_read(8'he4, d);
		chk(d, GLER_READ_ZERO);
		$display("unmapped test done");
		// back-to-back write and read, then a reset in mid-run
		route_exp = 32'ha5c3_9e81;
		reg_wr_rd(GLER_ROUTE_OFS, route_exp, d);
		chk(d, route_exp);
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		route_exp = GLER_ROUTE_RST;
		reg_read(GLER_ROUTE_OFS, d);
		chk(d, GLER_ROUTE_RST);
		fire(8'h0f);
		$display("order and reset test done");
		complete_run();
	end
endmodule // tb_gpio_low_event_router
`default_nettype wire
